// ==== hdl/sfdp_rom_params.svh ====
// Constants of the discovery parameter store: addresses, field
// values and reset values. Assumes inclusion by bare name.
`ifndef SFDP_ROM_PARAMS_SVH
`define SFDP_ROM_PARAMS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define SFDP_TBL_BASE     16'h1090
`define SFDP_FIRST_OFS    16'h0004
`define SFDP_LAST_OFS     16'h0020
`define SFDP_CTRL_ADDR    16'h1000
`define SFDP_STAT_ADDR    16'h1004
`define SFDP_CTRL_EN_BIT  0
`define SFDP_STAT_REJ_BIT 0
`define SFDP_CTRL_EN_RST  1'b1
`define SFDP_STAT_REJ_RST 1'b0
`define SFDP_RDATA_RST    32'h0000_0000

// ****************************************************************
// Table contents
// ****************************************************************
`define SFDP_DENSITY      32'h1fff_ffff
`define SFDP_Q144_MODE    3'h2
`define SFDP_Q144_DUMMY   5'h08
`define SFDP_Q144_OP      8'heb
`define SFDP_D122_MODE    3'h4
`define SFDP_D122_DUMMY   5'h08
`define SFDP_D122_OP      8'hbb
`define SFDP_Q444_MODE    3'h2
`define SFDP_Q444_DUMMY   5'h08
`define SFDP_Q444_OP      8'heb
`define SFDP_NONE_MODE    3'h7
`define SFDP_NONE_DUMMY   5'h1f
`define SFDP_NONE_OP      8'hff
`define SFDP_FEATURE      8'hfe
`define SFDP_RSVD_BYTE    8'hff
`define SFDP_ER1_SIZE     8'h0c
`define SFDP_ER1_OP       8'h20
`define SFDP_ER2_SIZE     8'h10
`define SFDP_ER2_OP       8'hd8
`define SFDP_ER3_SIZE     8'h12
`define SFDP_ER3_OP       8'hd8
`define SFDP_ER4_SIZE     8'h00
`define SFDP_ER4_OP       8'hff

`endif

// ==== hdl/sfdp_pkg.sv ====
// Types shared by the discovery parameter store.
// Assumes nothing beyond a SystemVerilog compiler.
package sfdp_pkg;

  // ****************************************************************
  // Register port request
  // ****************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sfdp_bus_req_type;

  // One-hot decode of an access target
  typedef enum logic [3:0] {
    SFDP_HIT_NONE  = 4'b0001,
    SFDP_HIT_TABLE = 4'b0010,
    SFDP_HIT_CTRL  = 4'b0100,
    SFDP_HIT_STAT  = 4'b1000
  } sfdp_hit_type;

endpackage

// ==== hdl/sfdp_rst_sync.sv ====
// Reset release synchroniser.
// Assumes an active-low asynchronous reset input.
`timescale 1ns/10ps
module sfdp_rst_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  output logic      o_rst_b
);
  logic meta_r;

  // Two stages; first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r  <= 1'b0;
      o_rst_b <= 1'b0;
    end else begin
      meta_r  <= 1'b1;
      o_rst_b <= meta_r;
    end
  end
endmodule // sfdp_rst_sync

// ==== hdl/sfdp_rom_table.sv ====
// Fixed dword table of the basic flash parameters, relative
// offsets 04h to 23h. Assumes a word index from the caller.
`timescale 1ns/10ps
`include "sfdp_rom_params.svh"
module sfdp_rom_table (
  input  wire logic [2:0]  i_idx,
  output logic      [31:0] o_word
);
  // Density as a named constant so its bytes can be sliced
  localparam logic [31:0] DENSITY = `SFDP_DENSITY;

  // Byte image, lowest relative offset first
  localparam logic [7:0] BYTES [32] = '{
    DENSITY[7:0], DENSITY[15:8],
    DENSITY[23:16], DENSITY[31:24],
    {`SFDP_Q144_MODE, `SFDP_Q144_DUMMY}, `SFDP_Q144_OP,
    {`SFDP_NONE_MODE, `SFDP_NONE_DUMMY}, `SFDP_NONE_OP,
    {`SFDP_NONE_MODE, `SFDP_NONE_DUMMY}, `SFDP_NONE_OP,
    {`SFDP_D122_MODE, `SFDP_D122_DUMMY}, `SFDP_D122_OP,
    `SFDP_FEATURE, `SFDP_RSVD_BYTE, `SFDP_RSVD_BYTE, `SFDP_RSVD_BYTE,
    `SFDP_RSVD_BYTE, `SFDP_RSVD_BYTE,
    {`SFDP_NONE_MODE, `SFDP_NONE_DUMMY}, `SFDP_NONE_OP,
    `SFDP_RSVD_BYTE, `SFDP_RSVD_BYTE,
    {`SFDP_Q444_MODE, `SFDP_Q444_DUMMY}, `SFDP_Q444_OP,
    `SFDP_ER1_SIZE, `SFDP_ER1_OP, `SFDP_ER2_SIZE, `SFDP_ER2_OP,
    `SFDP_ER3_SIZE, `SFDP_ER3_OP, `SFDP_ER4_SIZE, `SFDP_ER4_OP
  };

  logic [31:0] words [8];

  // Little-endian packing of each dword
  for (genvar i = 0; i < 8; i++) begin : g_word
    assign words[i] = {BYTES[4*i+3], BYTES[4*i+2],
                       BYTES[4*i+1], BYTES[4*i]};
  end

  assign o_word = words[i_idx];
endmodule // sfdp_rom_table

// ==== hdl/sfdp_param_rom.sv ====
// Discovery parameter store with its register port.
// Assumes a single-cycle master that never overlaps strobes.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "sfdp_rom_params.svh"

// Contract
// - Density dword reads 1FFFFFFFh
// - Quad address-data byte reads 48h
// - Quad address-data opcode reads EBh
// - Quad output-only fields all ones
// - Dual output-only fields all ones
// - Dual address-data byte reads 88h
// - Dual address-data opcode reads BBh
// - Feature byte FEh, four-wire mode flagged
// - Reserved bytes read FFh
// - Dual-all mode fields all ones
// - Four-wire quad read 48h then EBh
// - Erase type 1: 0Ch, 20h
// - Erase type 2: 10h, D8h
// - Erase type 3: 12h, D8h
// - Erase type 4 absent: 00h, FFh
// - Table based at 1090h
module sfdp_param_rom (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire sfdp_pkg::sfdp_bus_req_type i_bus,
  output logic      [31:0]              o_rdata,
  output logic                          o_wr_reject,
  output logic                          o_table_en
);
  import sfdp_pkg::*;

  // ****************************************************************
  // Reset and table
  // ****************************************************************
  logic        rst_b;
  logic [15:0] tbl_ofs;
  logic [2:0]  tbl_idx;
  logic [31:0] tbl_word;
  sfdp_hit_type hit;

  sfdp_rst_sync u_rst_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .o_rst_b (rst_b)
  );

  // Offset from the first dword held here
  assign tbl_ofs = i_bus.addr - `SFDP_TBL_BASE - `SFDP_FIRST_OFS;
  assign tbl_idx = tbl_ofs[4:2];

  sfdp_rom_table u_rom_table (
    .i_idx  (tbl_idx),
    .o_word (tbl_word)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic sfdp_hit_type decode(input logic [15:0] a);
    logic [15:0] ofs;
    ofs = a - `SFDP_TBL_BASE;
    if (a >= `SFDP_TBL_BASE && ofs >= `SFDP_FIRST_OFS &&
        ofs <= `SFDP_LAST_OFS && ofs[1:0] == 2'h0) begin
      decode = SFDP_HIT_TABLE;
    end else if (a == `SFDP_CTRL_ADDR) begin
      decode = SFDP_HIT_CTRL;
    end else if (a == `SFDP_STAT_ADDR) begin
      decode = SFDP_HIT_STAT;
    end else begin
      decode = SFDP_HIT_NONE;
    end
  endfunction

  assign hit = decode(i_bus.addr);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic        ctrl_en_r;
  logic        ctrl_en_nxt;
  logic        stat_rej_r;
  logic        stat_rej_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // Next control, status and read data
  always_comb begin
    ctrl_en_nxt  = ctrl_en_r;
    stat_rej_nxt = stat_rej_r;
    rdata_nxt    = `SFDP_RDATA_RST;
    if (i_bus.wr) begin
      case (hit)
        SFDP_HIT_CTRL: begin
          ctrl_en_nxt = i_bus.wdata[`SFDP_CTRL_EN_BIT];
        end
        SFDP_HIT_STAT: begin
          if (i_bus.wdata[`SFDP_STAT_REJ_BIT]) begin
            stat_rej_nxt = 1'b0;
          end
        end
        SFDP_HIT_TABLE: begin
          stat_rej_nxt = 1'b1;
        end
        default: begin
          stat_rej_nxt = stat_rej_r;
        end
      endcase
    end
    if (i_bus.rd) begin
      case (hit)
        SFDP_HIT_TABLE: begin
          if (ctrl_en_r) begin
            rdata_nxt = tbl_word;
          end
        end
        SFDP_HIT_CTRL: begin
          rdata_nxt[`SFDP_CTRL_EN_BIT] = ctrl_en_r;
        end
        SFDP_HIT_STAT: begin
          rdata_nxt[`SFDP_STAT_REJ_BIT] = stat_rej_r;
        end
        default: begin
          rdata_nxt = `SFDP_RDATA_RST;
        end
      endcase
    end
  end

  // Register stage
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_r  <= `SFDP_CTRL_EN_RST;
      stat_rej_r <= `SFDP_STAT_REJ_RST;
      rdata_r    <= `SFDP_RDATA_RST;
    end else begin
      ctrl_en_r  <= ctrl_en_nxt;
      stat_rej_r <= stat_rej_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign o_rdata     = rdata_r;
  assign o_wr_reject = stat_rej_r;
  assign o_table_en  = ctrl_en_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_b);

  // Enabled read of one table dword
  sequence s_tbl_rd(logic [15:0] a);
    i_bus.rd && i_bus.addr == a && ctrl_en_r;
  endsequence

  // Write to a table dword
  sequence s_tbl_wr(logic [15:0] a);
    i_bus.wr && i_bus.addr == a;
  endsequence

  density_word_a: assert property (
    s_tbl_rd(16'h1094) |=> o_rdata == 32'h1fff_ffff && o_rdata[31:24] == 8'h1f)
    else $error("density dword wrong");

  quad_io_cyc_a: assert property (
    s_tbl_rd(16'h1098) |=> o_rdata[7:0] == 8'h48 && o_rdata[7:5] == 3'h2
                        && o_rdata[4:0] == 5'h08)
    else $error("quad io cycle byte wrong");

  quad_io_op_a: assert property (
    s_tbl_rd(16'h1098) |=> o_rdata[15:8] == 8'heb)
    else $error("quad io opcode wrong");

  quad_out_none_a: assert property (
    s_tbl_rd(16'h1098) |=> o_rdata[23:21] == 3'h7 && o_rdata[20:16] == 5'h1f
                        && o_rdata[31:24] == 8'hff)
    else $error("quad out fields not all ones");

  dual_out_none_a: assert property (
    s_tbl_rd(16'h109c) |=> o_rdata[7:5] == 3'h7 && o_rdata[4:0] == 5'h1f
                        && o_rdata[15:8] == 8'hff)
    else $error("dual out fields not all ones");

  dual_io_cyc_a: assert property (
    s_tbl_rd(16'h109c) |=> o_rdata[23:16] == 8'h88 && o_rdata[23:21] == 3'h4
                        && o_rdata[20:16] == 5'h08)
    else $error("dual io cycle byte wrong");

  dual_io_op_a: assert property (
    s_tbl_rd(16'h109c) |=> o_rdata[31:24] == 8'hbb)
    else $error("dual io opcode wrong");

  feature_byte_a: assert property (
    s_tbl_rd(16'h10a0) |=> o_rdata[7:0] == 8'hfe && o_rdata[4] && !o_rdata[0])
    else $error("feature byte wrong");

  reserved_ones_a: assert property (
    (s_tbl_rd(16'h10a0) |=> o_rdata[31:8] == 24'hff_ffff) and
    (s_tbl_rd(16'h10a4) |=> o_rdata[15:0] == 16'hffff) and
    (s_tbl_rd(16'h10a8) |=> o_rdata[15:0] == 16'hffff))
    else $error("reserved byte not ones");

  dual_all_none_a: assert property (
    s_tbl_rd(16'h10a4) |=> o_rdata[23:21] == 3'h7 && o_rdata[20:16] == 5'h1f
                        && o_rdata[31:24] == 8'hff)
    else $error("dual all fields not all ones");

  four_wire_quad_a: assert property (
    s_tbl_rd(16'h10a8) |=> o_rdata[23:16] == 8'h48 && o_rdata[31:24] == 8'heb)
    else $error("four wire quad fields wrong");

  erase_one_a: assert property (
    s_tbl_rd(16'h10ac) |=> o_rdata[15:0] == 16'h200c)
    else $error("erase type 1 wrong");

  erase_two_a: assert property (
    s_tbl_rd(16'h10ac) |=> o_rdata[31:16] == 16'hd810)
    else $error("erase type 2 wrong");

  erase_three_a: assert property (
    s_tbl_rd(16'h10b0) |=> o_rdata[15:0] == 16'hd812)
    else $error("erase type 3 wrong");

  erase_four_a: assert property (
    s_tbl_rd(16'h10b0) |=> o_rdata[31:16] == 16'hff00)
    else $error("erase type 4 not absent");

  table_base_a: assert property (
    i_bus.rd && i_bus.addr == 16'h1090 |=> o_rdata == 32'h0)
    else $error("header area below table answered");

  // Table writes leave contents unchanged and raise the reject flag
  write_ignored_a: assert property (
    s_tbl_wr(16'h10a0) ##1 !i_bus.wr ##1 s_tbl_rd(16'h10a0)
    |=> o_wr_reject && o_rdata == 32'hffff_fffe)
    else $error("table write took effect");

  reject_set_wins_a: assert property (
    i_bus.wr && hit == SFDP_HIT_TABLE |=> o_wr_reject)
    else $error("reject flag lost");

  rdata_one_cycle_a: assert property (
    !i_bus.rd |=> o_rdata == 32'h0)
    else $error("read data held past its cycle");

  // ****************************************************************
  // Control and status checks
  // ****************************************************************
  // Write of the control word
  sequence s_ctrl_wr;
    i_bus.wr && hit == SFDP_HIT_CTRL;
  endsequence

  // Write of a one to the reject flag
  sequence s_stat_clr;
    i_bus.wr && hit == SFDP_HIT_STAT && i_bus.wdata[0];
  endsequence

  // Enable follows the written bit
  enable_write_a: assert property (
    s_ctrl_wr |=> o_table_en == $past(i_bus.wdata[0]))
    else $error("table enable not written");

  // Enable holds without a control write
  enable_hold_a: assert property (
    !(i_bus.wr && hit == SFDP_HIT_CTRL) |=> $stable(o_table_en))
    else $error("table enable changed by itself");

  // Writing a one clears the reject flag
  reject_clear_a: assert property (
    s_stat_clr |=> !o_wr_reject)
    else $error("reject flag not cleared");

  // Reject flag stays set until cleared
  reject_hold_a: assert property (
    o_wr_reject && !(i_bus.wr && hit == SFDP_HIT_STAT && i_bus.wdata[0])
    |=> o_wr_reject)
    else $error("reject flag dropped by itself");

  // Control word reads back in bit 0
  ctrl_readback_a: assert property (
    i_bus.rd && hit == SFDP_HIT_CTRL |=> o_rdata == {31'h0, $past(ctrl_en_r)})
    else $error("control read wrong");

  // Status word reads back in bit 0
  stat_readback_a: assert property (
    i_bus.rd && hit == SFDP_HIT_STAT |=> o_rdata == {31'h0, $past(stat_rej_r)})
    else $error("status read wrong");

  // Disabled table answers zero
  disabled_read_a: assert property (
    i_bus.rd && hit == SFDP_HIT_TABLE && !ctrl_en_r |=> o_rdata == 32'h0)
    else $error("disabled table answered");

  // Unmapped places answer zero
  unmapped_read_a: assert property (
    i_bus.rd && hit == SFDP_HIT_NONE |=> o_rdata == 32'h0)
    else $error("unmapped read answered");

  // Misaligned reads answer zero
  misaligned_read_a: assert property (
    i_bus.rd && i_bus.addr[1:0] != 2'h0 |=> o_rdata == 32'h0)
    else $error("misaligned read answered");

endmodule // sfdp_param_rom

// ==== testbench/sfdp_host_model.sv ====
// Host side model that drives the register port of the store.
// Assumes the store answers a read in the following cycle, no wait.
`timescale 1ns/10ps
module sfdp_host_model (
  input  wire logic                  i_clk,
  output sfdp_pkg::sfdp_bus_req_type o_bus,
  input  wire logic [31:0]           i_rdata
);
  import sfdp_pkg::*;
  // ********************
  // Bus cycles
  // ********************
  // Idle bus: no strobe
  initial o_bus = '0;

  // One write cycle, strobe one clock
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    o_bus.wr <= 1'b0;
    #1;
  endtask

  // One read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    o_bus.rd <= 1'b0;
    #1 v = i_rdata;
  endtask

  // Read latency taken from a mode and dummy byte
  function automatic logic [31:0] lat(input logic [7:0] b);
    return {29'h0, b[7:5]} + {27'h0, b[4:0]};
  endfunction
endmodule // sfdp_host_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the discovery parameter store.
// Assumes the host model for all register port traffic.
`timescale 1ns/10ps
module testbench;
  import sfdp_pkg::*;
  logic             i_clk;
  logic             i_rst_b;
  sfdp_bus_req_type bus;
  logic [31:0]      rdata;
  logic [31:0]      d;
  logic             wr_reject;
  logic             table_en;
  int               errors;
  int               check_count;
  // Expected words, lowest offset byte in bits 7:0
  logic [31:0]      exp_tbl [8] = '{32'h1fff_ffff, 32'hffff_eb48, 32'hbb88_ffff,
    32'hffff_fffe, 32'hffff_ffff, 32'heb48_ffff, 32'hd810_200c, 32'hff00_d812};
  logic [15:0]      bad [4] = '{16'h1090, 16'h108c, 16'h10b4, 16'h1095};

  // ********************
  // Clock and instances
  // ********************
  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;

  sfdp_param_rom DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_bus(bus), .o_rdata(rdata),
    .o_wr_reject(wr_reject), .o_table_en(table_en));
  sfdp_host_model host (.i_clk(i_clk), .o_bus(bus), .i_rdata(rdata));

  // ********************
  // Helpers
  // ********************
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts and verdict
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reset for two cycles, check reset levels, wait out the synchroniser
  task automatic do_reset();
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    #1 check("reset enable", {31'h0, table_en}, 32'h1);
    check("reset reject", {31'h0, wr_reject}, 32'h0);
    check("reset rdata", rdata, 32'h0);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask

  // Watchdog for a hung run
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    summarize();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    errors = 0;
    check_count = 0;
    i_rst_b = 1'b0;
    do_reset();
    // Whole table in address order from 1094h
    for (int i = 0; i < 8; i++) begin
      host.rd(16'h1094 + 16'(4 * i), d);
      check("table word", d, exp_tbl[i]);
    end
    // Read data stands one cycle only
    @(posedge i_clk);
    #1 check("rdata idle", rdata, 32'h0);
    // Field view of the read mode words
    host.rd(16'h1098, d);
    check("quad io mode", {29'h0, d[7:5]}, 32'h2);
    check("quad io dummy", {27'h0, d[4:0]}, 32'h8);
    check("quad io op", {24'h0, d[15:8]}, 32'heb);
    check("host latency", host.lat(d[7:0]), 32'ha);
    host.rd(16'h109c, d);
    check("dual io mode", {29'h0, d[23:21]}, 32'h4);
    check("dual io dummy", {27'h0, d[20:16]}, 32'h8);
    host.rd(16'h10a0, d);
    check("four wire flag", {31'h0, d[4]}, 32'h1);
    // Header, outside and misaligned places read zero
    foreach (bad[i]) begin
      host.rd(bad[i], d);
      check("unmapped read", d, 32'h0);
    end
    // Write to a table word is refused and flagged
    host.wr(16'h10a0, 32'h0000_0001);
    check("reject flag", {31'h0, wr_reject}, 32'h1);
    host.rd(16'h10a0, d);
    check("word after write", d, 32'hffff_fffe);
    host.rd(16'h1004, d);
    check("status read", d, 32'h1);
    host.wr(16'h1004, 32'h1);
    check("reject cleared", {31'h0, wr_reject}, 32'h0);
    // Table disabled, then enabled again
    host.wr(16'h1000, 32'h0);
    check("enable off", {31'h0, table_en}, 32'h0);
    host.rd(16'h1094, d);
    check("disabled read", d, 32'h0);
    host.rd(16'h1000, d);
    check("ctrl read", d, 32'h0);
    host.wr(16'h1000, 32'h1);
    host.rd(16'h10ac, d);
    check("erase word", d, 32'hd810_200c);
    // Reset in mid-run restores flags
    host.wr(16'h1000, 32'h0);
    host.wr(16'h10ac, 32'h0);
    do_reset();
    host.rd(16'h10b0, d);
    check("erase word after reset", d, 32'hff00_d812);
    summarize();
  end
endmodule // testbench
